// file: fsrpg_pkg.sv
// Shared constants and types for the fault-response and power-good supervisor
`default_nettype none

package fsrpg_pkg;

    // Widths of the sensed quantities and of the soft-start rise time
    localparam int VOLT_W = 12;
    localparam int TEMP_W = 9;
    localparam int CURR_W = 8;
    localparam int RISE_W = 16;

    // Fault response chosen per fault source
    typedef enum logic [1:0] {
        RESP_LATCH,
        RESP_RESTART,
        RESP_IGNORE
    } fsrpg_resp_t;

    // Supervisor states
    typedef enum logic [2:0] {
        ST_OFF,
        ST_SOFT,
        ST_RUN,
        ST_COOL_INT,
        ST_COOL_EXT,
        ST_DISCH,
        ST_HICCUP,
        ST_LATCHED
    } fsrpg_state_t;

    // Counts and limits
    localparam logic [1:0] OC_TRIP_COUNT = 2'h3;
    localparam logic [2:0] RESTART_RISE_PERIODS = 3'h7;
    localparam logic [9:0] EXT_OT_HYST_DEGC = 10'h014;
    localparam logic [VOLT_W-1:0] PG_HYST_BASE = 12'h008;

    // Status flag positions
    localparam int FLG_EXT_OT_FAULT = 0;
    localparam int FLG_EXT_OT_WARN = 1;
    localparam int FLG_INT_OT = 2;
    localparam int FLG_LS_OC_WARN = 3;
    localparam int FLG_OC_FAULT = 4;
    localparam int FLG_OV_FAULT = 5;
    localparam int FLG_OV_WARN = 6;
    localparam int NUM_FLAGS = 7;

    // Reset values
    localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 7'h00;
    localparam logic [RISE_W-1:0] RISE_CNT_RESET = 16'h0000;
    localparam logic [2:0] PERIOD_CNT_RESET = 3'h0;
    localparam logic [1:0] OC_CNT_RESET = 2'h0;

endpackage : fsrpg_pkg

`default_nettype wire

// file: fsrpg_pg_if.sv
// Signals between the supervisor core and its power-good window comparator
`timescale 1ns/100ps
`default_nettype none

interface fsrpg_pg_if;
    import fsrpg_pkg::*;
    logic [VOLT_W-1:0] sense;
    logic [VOLT_W-1:0] ov_warn;
    logic [VOLT_W-1:0] uv_warn;
    logic [1:0] scale_code;
    logic in_window;

    modport core (output sense, output ov_warn, output uv_warn,
                  output scale_code, input in_window);
    modport mon (input sense, input ov_warn, input uv_warn,
                 input scale_code, output in_window);
endinterface : fsrpg_pg_if

`default_nettype wire

// file: fsrpg_pg_window.sv
// Power-good window comparator with scale-dependent hysteresis
`timescale 1ns/100ps
`default_nettype none

module fsrpg_pg_window
    import fsrpg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Window signals
    fsrpg_pg_if.mon pg
);

    logic [VOLT_W:0] hyst;
    logic [VOLT_W:0] ov_lo;
    logic [VOLT_W:0] uv_hi;
    logic in_window_reg;
    logic in_window_next;

    // Hysteresis doubles each time the loop scale factor halves, up to scale code 2; code 3 uses the code 2 value
    always_comb begin
        hyst = {1'b0, PG_HYST_BASE} << ((pg.scale_code > 2'h2) ?
               2'h2 : pg.scale_code); // RULE3
        ov_lo = ({1'b0, pg.ov_warn} > hyst) ?
                ({1'b0, pg.ov_warn} - hyst) : 13'h0000;
        uv_hi = {1'b0, pg.uv_warn} + hyst;
    end

    // Leave at the warning limits, re-enter only inside the hysteresis
    always_comb begin
        in_window_next = in_window_reg;
        if (in_window_reg) begin
            if (pg.sense > pg.ov_warn || pg.sense < pg.uv_warn) begin // RULE2
                in_window_next = 1'b0;
            end
        end else if ({1'b0, pg.sense} <= ov_lo &&
                     {1'b0, pg.sense} >= uv_hi) begin // RULE2
            in_window_next = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            in_window_reg <= 1'b0;
        end else begin
            in_window_reg <= in_window_next;
        end
    end

    assign pg.in_window = in_window_reg;

    property p_win_enter;
        @(posedge clk) disable iff (sys_rst)
        $rose(in_window_reg) |-> ({1'b0, $past(pg.sense)} <= $past(ov_lo)
            && {1'b0, $past(pg.sense)} >= $past(uv_hi));
    endproperty
    a_win_enter: assert property (p_win_enter) // RULE3
        else $error("power-good window entered outside hysteresis");

    property p_win_leave;
        @(posedge clk) disable iff (sys_rst)
        $fell(in_window_reg) |-> ($past(pg.sense) > $past(pg.ov_warn)
            || $past(pg.sense) < $past(pg.uv_warn));
    endproperty
    a_win_leave: assert property (p_win_leave) // RULE2
        else $error("power-good window left while inside warning limits");

endmodule : fsrpg_pg_window

`default_nettype wire

// file: fsrpg_supervisor.sv
// Fault-response supervisor driving the FET enables and power-good output
//
// Behaviour
// (RULE1) Power-good is released only in regulation, after start-up, with the output inside the window.
// (RULE2) The window bounds are the programmable overvoltage and undervoltage warning limits.
// (RULE3) Window hysteresis doubles for each halving of the output loop scale factor; scale code 3 keeps the scale code 2 value.
// (RULE4) Any active fault pulls power-good low.
// (RULE5) An external over-temperature fault not ignored turns both FETs off; restart waits for a 20 degree fall.
// (RULE6) Ignored external over-temperature or overcurrent faults leave modulation running and power-good high.
// (RULE7) Warnings keep modulation and pull power-good low unless the related fault is ignored.
// (RULE8) Junction over-temperature cannot be ignored: both FETs off until the die has cooled, then restart.
// (RULE9) An overcurrent fault under latch-off stops both FETs after three counts and stays off until reset or re-enable.
// (RULE10) An overcurrent fault under restart waits seven soft-start rise periods before restarting.
// (RULE11) High-side peak current always ends the switching cycle early, even when the fault is ignored.
// (RULE12) An overvoltage fault forces the high-side FET off; a select bit chooses the low-side discharge mode.
// (RULE13) After overvoltage discharge under restart, seven rise periods pass before restart.
// (RULE14) Overcurrent is counted per switching cycle and trips after three consecutive events.
// (RULE15) Each fault but junction over-temperature has its own latch, restart or ignore setting; a latch lasts until reset or re-enable.
// (RULE16) Every fault and warning sets a sticky flag and raises the alert unless masked.
`timescale 1ns/100ps
`default_nettype none

module fsrpg_supervisor
    import fsrpg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Converter control
    input wire logic converter_enable_in,
    input wire logic [RISE_W-1:0] soft_start_rise_time,
    input wire logic pwm_cycle_strobe,
    // Sensed quantities
    input wire logic [VOLT_W-1:0] diff_sense_out,
    input wire logic [TEMP_W-1:0] ext_temp,
    input wire logic int_temp_hot,
    input wire logic [CURR_W-1:0] lowside_current,
    input wire logic hs_oc_event,
    // Limits
    input wire logic [VOLT_W-1:0] out_overvolt_warn_threshold,
    input wire logic [VOLT_W-1:0] out_undervolt_warn_threshold,
    input wire logic [VOLT_W-1:0] out_overvolt_fault_threshold,
    input wire logic [VOLT_W-1:0] out_undervolt_fault_threshold,
    input wire logic [TEMP_W-1:0] ext_temp_fault_threshold,
    input wire logic [TEMP_W-1:0] ext_temp_warn_threshold,
    input wire logic [CURR_W-1:0] lowside_current_fault_threshold,
    input wire logic [CURR_W-1:0] lowside_current_warn_threshold,
    input wire logic [1:0] loop_scale_code,
    // Fault responses
    input wire fsrpg_resp_t ext_ot_resp,
    input wire fsrpg_resp_t oc_resp,
    input wire fsrpg_resp_t ov_resp,
    input wire logic overvolt_lowside_action_select,
    // Status and alert
    input wire logic [NUM_FLAGS-1:0] status_clear,
    input wire logic [NUM_FLAGS-1:0] alert_mask,
    output logic [NUM_FLAGS-1:0] status_flags,
    output logic alert_out,
    output logic [2:0] state_out,
    // Power stage
    output logic fet_pwm_mode,
    output logic hs_force_off,
    output logic ls_force_on,
    output logic cycle_terminate,
    // Open-drain power good
    output logic power_good_out_o,
    output logic power_good_out_oe
);

    fsrpg_pg_if pg ();

    fsrpg_pg_window u_window (
        .clk(clk),
        .sys_rst(sys_rst),
        .pg(pg.mon)
    );

    assign pg.sense = diff_sense_out;
    assign pg.ov_warn = out_overvolt_warn_threshold;
    assign pg.uv_warn = out_undervolt_warn_threshold;
    assign pg.scale_code = loop_scale_code;

    ////////////////////////////////////////////////////////////////////////
    // Fault and warning conditions

    logic ext_ot_fault;
    logic ext_ot_warn;
    logic ext_ot_cooled;
    logic ls_oc_event;
    logic ls_oc_warn;
    logic ov_fault;
    logic ov_warn;
    logic uv_reached;
    logic oc_trip;
    logic rise_done;
    logic active;

    fsrpg_state_t state_reg;
    fsrpg_state_t state_next;
    logic [RISE_W-1:0] rise_cnt_reg;
    logic [RISE_W-1:0] rise_cnt_next;
    logic [2:0] period_cnt_reg;
    logic [2:0] period_cnt_next;
    logic [1:0] oc_cnt_reg;
    logic [1:0] oc_cnt_next;
    logic ls_hold_reg;
    logic ls_hold_next;

    always_comb begin
        ext_ot_fault = ext_temp > ext_temp_fault_threshold;
        ext_ot_warn = ext_temp > ext_temp_warn_threshold;
        ext_ot_cooled = ({1'b0, ext_temp} + EXT_OT_HYST_DEGC) <=
                        {1'b0, ext_temp_fault_threshold}; // RULE5
        ls_oc_event = lowside_current > lowside_current_fault_threshold;
        ls_oc_warn = lowside_current > lowside_current_warn_threshold;
        ov_fault = diff_sense_out > out_overvolt_fault_threshold;
        ov_warn = diff_sense_out > out_overvolt_warn_threshold;
        uv_reached = diff_sense_out <= out_undervolt_fault_threshold;
        oc_trip = oc_cnt_reg == OC_TRIP_COUNT; // RULE14
        rise_done = ({1'b0, rise_cnt_reg} + 17'h00001) >=
                    {1'b0, soft_start_rise_time};
        active = state_reg == ST_SOFT || state_reg == ST_RUN;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencing state machine

    always_comb begin
        state_next = state_reg;
        rise_cnt_next = rise_cnt_reg;
        period_cnt_next = period_cnt_reg;
        oc_cnt_next = oc_cnt_reg;
        ls_hold_next = ls_hold_reg;
        // Consecutive overcurrent cycles, high-side or low-side
        if (!active) begin
            oc_cnt_next = OC_CNT_RESET;
        end else if (pwm_cycle_strobe) begin
            if (hs_oc_event || ls_oc_event) begin // RULE14
                oc_cnt_next = oc_trip ? oc_cnt_reg : oc_cnt_reg + 2'h1;
            end else begin
                oc_cnt_next = OC_CNT_RESET;
            end
        end
        if (!converter_enable_in) begin
            state_next = ST_OFF; // RULE15
        end else begin
            case (state_reg)
                ST_OFF: begin
                    state_next = ST_SOFT;
                end
                ST_SOFT, ST_RUN: begin
                    if (int_temp_hot) begin
                        state_next = ST_COOL_INT; // RULE8
                    end else if (ext_ot_fault && ext_ot_resp != RESP_IGNORE) begin
                        state_next = (ext_ot_resp == RESP_LATCH) ?
                                     ST_LATCHED : ST_COOL_EXT; // RULE5
                    end else if (ov_fault && ov_resp != RESP_IGNORE) begin
                        state_next = ST_DISCH; // RULE12
                        ls_hold_next = !overvolt_lowside_action_select;
                    end else if (oc_trip && oc_resp != RESP_IGNORE) begin
                        state_next = (oc_resp == RESP_LATCH) ?
                                     ST_LATCHED : ST_HICCUP; // RULE9 RULE10
                    end else if (state_reg == ST_SOFT && rise_done) begin
                        state_next = ST_RUN;
                    end
                end
                ST_COOL_INT: begin
                    if (!int_temp_hot) begin
                        state_next = ST_SOFT; // RULE8
                    end
                end
                ST_COOL_EXT: begin
                    if (ext_ot_cooled) begin
                        state_next = ST_SOFT; // RULE5
                    end
                end
                ST_DISCH: begin
                    if (uv_reached) begin
                        state_next = (ov_resp == RESP_RESTART) ?
                                     ST_HICCUP : ST_LATCHED; // RULE13
                    end
                end
                ST_HICCUP: begin
                    if (rise_done && period_cnt_reg ==
                        RESTART_RISE_PERIODS - 3'h1) begin
                        state_next = ST_SOFT; // RULE10 RULE13
                    end
                end
                default: begin
                    state_next = ST_LATCHED; // RULE15
                end
            endcase
        end
        // Rise-period timers restart on every state change
        if (state_next != state_reg) begin
            rise_cnt_next = RISE_CNT_RESET;
            period_cnt_next = PERIOD_CNT_RESET;
        end else if (rise_done) begin
            rise_cnt_next = RISE_CNT_RESET;
            period_cnt_next = period_cnt_reg + 3'h1;
        end else begin
            rise_cnt_next = rise_cnt_reg + 16'h0001;
        end
        if (state_next == ST_OFF || state_next == ST_SOFT) begin
            ls_hold_next = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_OFF;
            rise_cnt_reg <= RISE_CNT_RESET;
            period_cnt_reg <= PERIOD_CNT_RESET;
            oc_cnt_reg <= OC_CNT_RESET;
            ls_hold_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            rise_cnt_reg <= rise_cnt_next;
            period_cnt_reg <= period_cnt_next;
            oc_cnt_reg <= oc_cnt_next;
            ls_hold_reg <= ls_hold_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power stage and power-good outputs

    logic fault_pull;
    logic warn_pull;
    logic pwm_next;
    logic ls_next;
    logic term_next;
    logic pg_oe_next;
    logic pwm_reg;
    logic hs_off_reg;
    logic ls_reg;
    logic term_reg;
    logic pg_oe_reg;

    always_comb begin
        fault_pull = int_temp_hot ||
                     (ext_ot_fault && ext_ot_resp != RESP_IGNORE) ||
                     (oc_trip && oc_resp != RESP_IGNORE) ||
                     (ov_fault && ov_resp != RESP_IGNORE); // RULE4 RULE6
        warn_pull = (ext_ot_warn && ext_ot_resp != RESP_IGNORE) ||
                    (ls_oc_warn && oc_resp != RESP_IGNORE) ||
                    (ov_warn && ov_resp != RESP_IGNORE); // RULE7
        pwm_next = active; // RULE6 RULE7
        ls_next = state_reg == ST_DISCH ||
                  (ls_hold_reg && state_reg != ST_OFF); // RULE12
        term_next = hs_oc_event && active; // RULE11
        pg_oe_next = !(state_reg == ST_RUN && pg.in_window &&
                       !fault_pull && !warn_pull); // RULE1
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pwm_reg <= 1'b0;
            hs_off_reg <= 1'b1;
            ls_reg <= 1'b0;
            term_reg <= 1'b0;
            pg_oe_reg <= 1'b1;
        end else begin
            pwm_reg <= pwm_next;
            hs_off_reg <= !pwm_next;
            ls_reg <= ls_next;
            term_reg <= term_next;
            pg_oe_reg <= pg_oe_next;
        end
    end

    assign fet_pwm_mode = pwm_reg;
    assign hs_force_off = hs_off_reg;
    assign ls_force_on = ls_reg;
    assign cycle_terminate = term_reg;
    assign power_good_out_o = 1'b0;
    assign power_good_out_oe = pg_oe_reg;
    assign state_out = state_reg;

    ////////////////////////////////////////////////////////////////////////
    // Sticky status flags and alert

    logic [NUM_FLAGS-1:0] cond;
    logic [NUM_FLAGS-1:0] cond_prev_reg;
    logic [NUM_FLAGS-1:0] flags_reg;
    logic [NUM_FLAGS-1:0] flags_next;

    always_comb begin
        cond = '0;
        cond[FLG_EXT_OT_FAULT] = ext_ot_fault;
        cond[FLG_EXT_OT_WARN] = ext_ot_warn;
        cond[FLG_INT_OT] = int_temp_hot;
        cond[FLG_LS_OC_WARN] = ls_oc_warn;
        cond[FLG_OC_FAULT] = oc_trip;
        cond[FLG_OV_FAULT] = ov_fault;
        cond[FLG_OV_WARN] = ov_warn;
    end

    // A new event in the clearing cycle keeps its flag set
    for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
        assign flags_next[i] = (cond[i] && !cond_prev_reg[i]) ||
                               (flags_reg[i] && !status_clear[i]); // RULE16
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flags_reg <= FLAGS_RESET;
            cond_prev_reg <= FLAGS_RESET;
        end else begin
            flags_reg <= flags_next;
            cond_prev_reg <= cond;
        end
    end

    assign status_flags = flags_reg;
    assign alert_out = |(flags_reg & ~alert_mask); // RULE16

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_pg_release;
        @(posedge clk) disable iff (sys_rst)
        !power_good_out_oe |-> $past(state_reg == ST_RUN && pg.in_window);
    endproperty
    a_pg_release: assert property (p_pg_release) // RULE1
        else $error("power good released outside regulation window");

    property p_int_ot_pull;
        @(posedge clk) disable iff (sys_rst)
        int_temp_hot |=> power_good_out_oe;
    endproperty
    a_int_ot_pull: assert property (p_int_ot_pull) // RULE4
        else $error("power good not pulled low on fault");

    property p_int_ot_off;
        @(posedge clk) disable iff (sys_rst)
        (int_temp_hot && converter_enable_in && active) |->
            ##2 (!fet_pwm_mode && hs_force_off && !ls_force_on);
    endproperty
    a_int_ot_off: assert property (p_int_ot_off) // RULE8
        else $error("FETs not off after junction over-temperature");

    property p_ext_latch;
        @(posedge clk) disable iff (sys_rst)
        (active && converter_enable_in && !int_temp_hot && ext_ot_fault
            && ext_ot_resp == RESP_LATCH) |=> state_reg == ST_LATCHED;
    endproperty
    a_ext_latch: assert property (p_ext_latch) // RULE5
        else $error("external over-temperature latch not taken");

    property p_ext_cool_cause;
        @(posedge clk) disable iff (sys_rst)
        (state_reg == ST_COOL_EXT && $past(state_reg) != ST_COOL_EXT) |->
            $past(ext_ot_resp) == RESP_RESTART;
    endproperty
    a_ext_cool_cause: assert property (p_ext_cool_cause) // RULE6
        else $error("external over-temperature acted while not restart");

    property p_oc_count;
        @(posedge clk) disable iff (sys_rst)
        (state_reg == ST_HICCUP && $past(state_reg) != ST_HICCUP
            && $past(state_reg) != ST_DISCH) |-> $past(oc_cnt_reg) == 2'h3;
    endproperty
    a_oc_count: assert property (p_oc_count) // RULE14
        else $error("overcurrent hiccup without three events");

    property p_hiccup_len;
        @(posedge clk) disable iff (sys_rst)
        (state_reg == ST_SOFT && $past(state_reg) == ST_HICCUP) |->
            ($past(period_cnt_reg) == 3'h6 && $past(rise_done));
    endproperty
    a_hiccup_len: assert property (p_hiccup_len) // RULE10
        else $error("restart before seven rise periods");

    property p_peak_limit;
        @(posedge clk) disable iff (sys_rst)
        (hs_oc_event && active) |=> cycle_terminate;
    endproperty
    a_peak_limit: assert property (p_peak_limit) // RULE11
        else $error("peak current did not end the cycle");

    property p_ov_disch;
        @(posedge clk) disable iff (sys_rst)
        state_reg == ST_DISCH |=> (ls_force_on && hs_force_off);
    endproperty
    a_ov_disch: assert property (p_ov_disch) // RULE12
        else $error("overvoltage discharge outputs wrong");

    property p_latch_hold;
        @(posedge clk) disable iff (sys_rst)
        (state_reg == ST_LATCHED && converter_enable_in) |=>
            state_reg == ST_LATCHED;
    endproperty
    a_latch_hold: assert property (p_latch_hold) // RULE9
        else $error("latched shutdown left without re-enable");

    property p_alert;
        @(posedge clk) disable iff (sys_rst)
        (|(flags_next & ~flags_reg & ~alert_mask)) |=> alert_out;
    endproperty
    a_alert: assert property (p_alert) // RULE16
        else $error("unmasked event raised no alert");

endmodule : fsrpg_supervisor

`default_nettype wire

// file: fsrpg_stage_model.sv
// Power stage and output sense model facing the supervisor
`timescale 1ns/100ps
`default_nettype none

module fsrpg_stage_model
    import fsrpg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Stage control and wanted output
    input wire logic ls_force_on,
    input wire logic [VOLT_W-1:0] target,
    // Sensed output and switching cycle strobe
    output logic [VOLT_W-1:0] sense,
    output logic strobe
);
    logic [1:0] div_reg;

    // Forced low side discharges the output step by step
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_reg <= 2'h0;
            sense <= 12'h000;
        end else begin
            div_reg <= div_reg + 2'h1;
            if (!ls_force_on)
                sense <= target;
            else if (sense > 12'h100)
                sense <= sense - 12'h100;
            else
                sense <= 12'h000;
        end
    end
    assign strobe = (div_reg == 2'h3);
endmodule : fsrpg_stage_model

`default_nettype wire

// file: testbench.sv
// Self-checking bench for the fault-response and power-good supervisor
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin mismatches++; \
$display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
`define WT(k) repeat (k) @(negedge clk)
`define WAITC(c) n = 0; while (!(c) && n < 400) begin @(negedge clk); n++; end

module testbench
    import fsrpg_pkg::*;
;
    typedef struct {
        fsrpg_resp_t ot;
        logic [TEMP_W-1:0] t;
        logic hot;
        logic [VOLT_W-1:0] v;
        logic [CURR_W-1:0] i;
        fsrpg_state_t st;
        logic oe;
        logic ls;
    } fsrpg_row_t;
    logic clk = 1'h0;
    logic sys_rst = 1'h1;
    logic converter_enable_in = 1'h0;
    logic [RISE_W-1:0] soft_start_rise_time = 16'h0004;
    logic int_temp_hot = 1'h0;
    logic hs_oc_event = 1'h0;
    logic pwm_cycle_strobe;
    logic [VOLT_W-1:0] diff_sense_out;
    logic [VOLT_W-1:0] target = 12'h800, out_overvolt_warn_threshold = 12'ha00;
    logic [VOLT_W-1:0] out_undervolt_warn_threshold = 12'h600,
        out_undervolt_fault_threshold = 12'h400;
    logic [TEMP_W-1:0] ext_temp = 9'h020;
    logic [CURR_W-1:0] lowside_current = 8'h10;
    logic [1:0] loop_scale_code = 2'h0;
    fsrpg_resp_t ext_ot_resp = RESP_LATCH;
    fsrpg_resp_t oc_resp = RESP_LATCH;
    fsrpg_resp_t ov_resp = RESP_LATCH;
    logic overvolt_lowside_action_select = 1'h1;
    logic [NUM_FLAGS-1:0] status_clear = 7'h00;
    logic [NUM_FLAGS-1:0] alert_mask = 7'h00;
    logic [NUM_FLAGS-1:0] status_flags;
    logic alert_out, fet_pwm_mode, hs_force_off, ls_force_on, cycle_terminate;
    logic power_good_out_o, power_good_out_oe;
    logic [2:0] state_out;
    int mismatches = 0;
    int check_count = 0;
    int n;
    int cyc = 0;
    fsrpg_row_t rows [8] = '{
        '{RESP_IGNORE, 9'h070, 1'h0, 12'h800, 8'h10, ST_RUN, 1'h0, 1'h0},
        '{RESP_LATCH, 9'h070, 1'h0, 12'h800, 8'h10, ST_LATCHED, 1'h1, 1'h0},
        '{RESP_RESTART, 9'h070, 1'h0, 12'h800, 8'h10, ST_COOL_EXT, 1'h1, 1'h0},
        '{RESP_IGNORE, 9'h05f, 1'h0, 12'h800, 8'h10, ST_RUN, 1'h0, 1'h0},
        '{RESP_LATCH, 9'h05f, 1'h0, 12'h800, 8'h10, ST_RUN, 1'h1, 1'h0},
        '{RESP_IGNORE, 9'h020, 1'h1, 12'h800, 8'h10, ST_COOL_INT, 1'h1, 1'h0},
        '{RESP_LATCH, 9'h020, 1'h0, 12'h800, 8'h70, ST_RUN, 1'h1, 1'h0},
        '{RESP_LATCH, 9'h020, 1'h0, 12'hd00, 8'h10, ST_DISCH, 1'h1, 1'h1}
    };

    fsrpg_supervisor u_fsrpg_supervisor (.clk, .sys_rst, .converter_enable_in,
        .soft_start_rise_time, .pwm_cycle_strobe, .diff_sense_out, .ext_temp,
        .int_temp_hot, .lowside_current, .hs_oc_event,
        .out_overvolt_warn_threshold, .out_undervolt_warn_threshold,
        .out_overvolt_fault_threshold(12'hc00), .out_undervolt_fault_threshold,
        .ext_temp_fault_threshold(9'h064), .ext_temp_warn_threshold(9'h05a),
        .lowside_current_fault_threshold(8'h80),
        .lowside_current_warn_threshold(8'h60), .loop_scale_code,
        .ext_ot_resp, .oc_resp, .ov_resp, .overvolt_lowside_action_select,
        .status_clear, .alert_mask, .status_flags, .alert_out, .state_out,
        .fet_pwm_mode, .hs_force_off, .ls_force_on, .cycle_terminate,
        .power_good_out_o, .power_good_out_oe);
    fsrpg_stage_model u_fsrpg_stage_model (.clk, .sys_rst, .ls_force_on,
        .target, .sense(diff_sense_out), .strobe(pwm_cycle_strobe));

    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results

    task automatic start;
        converter_enable_in = 1'h0;
        `WT(2);
        converter_enable_in = 1'h1;
        `WAITC(state_out == ST_RUN)
        `WT(4);
    endtask : start

    // Counts the restart wait and lifts the fault that caused it
    task automatic hiccup(input int len, input logic ls);
        `WAITC(state_out == ST_HICCUP)
        target = 12'h800;
        hs_oc_event = 1'h0;
        `CHK(ls_force_on, ls)
        n = 0;
        while (state_out == ST_HICCUP && n < 400) begin
            @(negedge clk);
            n++;
        end
        `CHK(n, len)
    endtask : hiccup

    ////////////////////////////////////////////////////////////////////////
    initial begin
        `WT(2);
        sys_rst = 1'h0;
        `CHK(state_out, 3'h0)
        `CHK(power_good_out_oe, 1'h1)
        `CHK(status_flags, FLAGS_RESET)
        start();
        `CHK(power_good_out_oe, 1'h0)
        `CHK(fet_pwm_mode, 1'h1)
        $display("reset and start done");
        foreach (rows[r]) begin
            ext_ot_resp = rows[r].ot;
            start();
            ext_temp = rows[r].t;
            int_temp_hot = rows[r].hot;
            target = rows[r].v;
            lowside_current = rows[r].i;
            `WT(6);
            `CHK(state_out, rows[r].st)
            `CHK(power_good_out_oe, rows[r].oe)
            `CHK(ls_force_on, rows[r].ls)
            ext_temp = 9'h020;
            int_temp_hot = 1'h0;
            target = 12'h800;
            lowside_current = 8'h10;
        end
        $display("table done");
        for (int k = 0; k < 3; k++) begin
            loop_scale_code = 2'(k);
            start();
            target = 12'ha01;
            `WT(5);
            `CHK(power_good_out_oe, 1'h1)
            target = 12'ha01 - (PG_HYST_BASE << k);
            `WT(5);
            `CHK(power_good_out_oe, 1'h1)
            target = target - 12'h001;
            `WT(5);
            `CHK(power_good_out_oe, 1'h0)
        end
        target = 12'h800;
        $display("window done");
        oc_resp = RESP_RESTART;
        start();
        hs_oc_event = 1'h1;
        hiccup(28, 1'h0);
        `CHK(status_flags[FLG_OC_FAULT], 1'h1)
        `CHK(alert_out, 1'h1)
        alert_mask = 7'h7f;
        `WT(1);
        `CHK(alert_out, 1'h0)
        ov_resp = RESP_RESTART;
        overvolt_lowside_action_select = 1'h0;
        soft_start_rise_time = 16'h0003;
        start();
        target = 12'hd00;
        hiccup(21, 1'h1);
        overvolt_lowside_action_select = 1'h1;
        $display("restart done");
        oc_resp = RESP_LATCH;
        start();
        hs_oc_event = 1'h1;
        `WAITC(state_out == ST_LATCHED)
        hs_oc_event = 1'h0;
        `WT(10);
        `CHK(state_out, ST_LATCHED)
        `CHK({fet_pwm_mode, ls_force_on, hs_force_off}, 3'h1)
        oc_resp = RESP_IGNORE;
        start();
        hs_oc_event = 1'h1;
        `WAITC(cycle_terminate == 1'h1)
        `CHK(cycle_terminate, 1'h1)
        `WT(16);
        `CHK(state_out, ST_RUN)
        `CHK(power_good_out_oe, 1'h0)
        out_undervolt_warn_threshold = 12'h900;
        `WT(5);
        `CHK({power_good_out_o, power_good_out_oe}, 2'h1)
        $display("latch and ignore done");
        results();
    end
endmodule : testbench

`default_nettype wire
